// ---- epe_top.sv ----
// Edge position evaluator: AHB-Lite register slave, measurement rate
// generator, frame averaging, edge search, segments and edge filter.
// Assumes pixels arrive on I_REF_CLK, NPIX per line after each line request.
`timescale 1ns/1ps
`default_nettype none
`include "epe_defs.svh"
// Notes on behaviour
// - falling program: first light-dark from origin
// - rising program: first dark-light from origin
// - diameter: first light-dark, last dark-light
// - gap: first dark-light, then next light-dark
// - segment program: all edges, both polarities
// - edge numbering follows search direction
// - positions relative to range midpoint, signed
// - up to 8 segments over 16 edges
// - index 0 is search origin (range end in reverse), then in search order
// - segment 0-0 is undefined, excluded
// - default four edges; missing edges read no-peak
// - rate 0.1 to 5 kHz, 1 Hz steps
// - line sampling never above 15 kHz
// - streaming out limits rate to 100 Hz
// - averaging on: several frames averaged; off: one
// - averaging off holds exposure fixed
// - counter and timestamp cleared independently
// - edges only inside start/end window percentages
// - filter arms once above upper threshold
// - below lower threshold: disarm and rearm
// - active filter outputs last value below upper
module epe_top
  import epe_pkg::*;
#(
  parameter int NPIX = 1024,
  parameter int PW = 12,
  parameter int AVG_FRAMES = 4,
  parameter int LINE_GAP_CYC = (`EPE_CLK_HZ + `EPE_LINE_MAX_HZ - 1) / `EPE_LINE_MAX_HZ
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_PIX_VALID,
  input wire logic [PW-1:0] I_PIX_DATA,
  output logic O_LINE_REQ,
  output logic O_EXPO_FIXED,
  output logic O_MEAS_DONE,
  output logic [15:0] O_RESULT,
  output logic O_RESULT_VALID,
  output logic O_FILT_ACTIVE
);
  localparam int IW = $clog2(NPIX) + 1;
  localparam int FSH = $clog2(AVG_FRAMES);
  localparam int SW = PW + FSH;
  localparam int TS_CYC = `EPE_TS_UNIT_NS / `EPE_CLK_NS;
  localparam int GW = $clog2(LINE_GAP_CYC + 1);
  localparam logic [27:0] CLK_HZ = 28'(`EPE_CLK_HZ);
  localparam logic [12:0] RMIN = 13'(`EPE_RATE_MIN_HZ);
  localparam logic [12:0] RMAX = 13'(`EPE_RATE_MAX_HZ);
  localparam logic [12:0] RSTRM = 13'(`EPE_STREAM_HZ);

  epe_ctrl_t ctrl_r;
  logic [PW-1:0] thr_r;
  logic [6:0] roi_lo_r, roi_hi_r;
  logic [12:0] rate_r;
  logic signed [15:0] fhi_r, flo_r;
  logic [31:0] segw_r [4];
  logic [31:0] cnt_r, ts_r;
  logic ph_we_r;
  logic [7:0] ph_addr_r;
  logic clr_cnt, clr_ts;
  logic [31:0] rd_data;
  epe_state_t state_r;
  logic [27:0] acc_r;
  logic tick_r;
  logic [7:0] us_r;
  logic [GW-1:0] gap_r;
  logic [IW-1:0] idx_r, lo_r, hi_r;
  logic [FSH:0] frq_r, fdn_r, nfr_r;
  logic line_act_r;
  logic [SW-1:0] sum_mem [NPIX];
  logic prev_light_r;
  logic [IW-1:0] epos_r [16];
  logic [15:0] epol_r;
  logic [4:0] ecnt_r, wk_r;
  epe_res_t ord_r [16];
  epe_res_t ra_r, rb_r, seg_r [8];
  logic gap_open_r;
  logic fact_r;
  logic signed [15:0] held_r;

  wire acc_ok = I_HSEL & I_HTRANS[1] & I_HREADY;

  // Signed half-pixel offset from the window midpoint
  function automatic logic signed [15:0] rel(input logic [IW:0] hp);
    logic signed [IW:0] d; // Signed so the size cast extends the sign
    d = hp - ({1'b0, lo_r} + {1'b0, hi_r});
    rel = ctrl_r.meas_inv ? 16'(-d) : 16'(d);
  endfunction

  function automatic logic [31:0] rword(input epe_res_t r);
    rword = r.val ? {{16{r.pos[15]}}, r.pos} : `EPE_NOPEAK;
  endfunction

  // Edge by number; index 0 is the origin of the window
  function automatic epe_res_t pick(input logic [4:0] n);
    pick = '0;
    if (n == 5'h00) begin
      pick.val = 1'b1;
      pick.pos = ctrl_r.search_rev ? rel({hi_r, 1'b0}) : rel({lo_r, 1'b0});
    end else if (n <= ecnt_r) begin
      pick = ord_r[4'(n - 5'h01)];
    end
  endfunction

  // Bus address phase, registered for the data phase
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ph_we_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_we_r <= acc_ok & I_HWRITE;
      ph_addr_r <= I_HADDR[7:0];
    end
  end

  // Zero wait states: read data is fetched during the address phase
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_HRDATA <= 32'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else if (acc_ok & ~I_HWRITE) begin
      O_HRDATA <= rd_data;
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    rd_data = 32'h0;
    if (I_HADDR[7:6] == `EPE_A_EDGE) begin
      rd_data = rword(ord_r[I_HADDR[5:2]]);
    end else if (I_HADDR[7:5] == `EPE_A_SEG) begin
      rd_data = rword(seg_r[I_HADDR[4:2]]);
    end else if (I_HADDR[7:4] == `EPE_A_SEGW) begin
      rd_data = segw_r[I_HADDR[3:2]];
    end else begin
      case (I_HADDR[7:0])
        `EPE_A_CTRL: rd_data = {24'h0, ctrl_r};
        `EPE_A_THR: rd_data = 32'(thr_r);
        `EPE_A_ROI: rd_data = {17'h0, roi_hi_r, 1'b0, roi_lo_r};
        `EPE_A_RATE: rd_data = {19'h0, rate_r};
        `EPE_A_FHI: rd_data = {{16{fhi_r[15]}}, fhi_r};
        `EPE_A_FLO: rd_data = {{16{flo_r[15]}}, flo_r};
        `EPE_A_STAT: rd_data = {24'h0, fact_r, state_r != EPE_IDLE, 1'b0, ecnt_r};
        `EPE_A_CNT: rd_data = cnt_r;
        `EPE_A_TS: rd_data = ts_r;
        `EPE_A_RESA: rd_data = rword(ra_r);
        `EPE_A_RESB: rd_data = rword(rb_r);
        default: rd_data = 32'h0;
      endcase
    end
  end

  // Command strobes for the two clear actions
  assign clr_cnt = ph_we_r & (ph_addr_r == `EPE_A_CMD) & I_HWDATA[`EPE_CMD_CLR_CNT];
  assign clr_ts = ph_we_r & (ph_addr_r == `EPE_A_CMD) & I_HWDATA[`EPE_CMD_CLR_TS];

  // Configuration writes; rate and window are clamped to legal ranges
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_r <= epe_ctrl_t'(`EPE_CTRL_RST);
      thr_r <= `EPE_THR_RST;
      roi_lo_r <= `EPE_ROI_LO_RST;
      roi_hi_r <= `EPE_ROI_HI_RST;
      rate_r <= `EPE_RATE_RST;
      fhi_r <= 16'sh7fff;
      flo_r <= 16'sh0000;
      segw_r[0] <= `EPE_SEGW0_RST;
      segw_r[1] <= `EPE_SEGW1_RST;
      segw_r[2] <= 32'h0;
      segw_r[3] <= 32'h0;
    end else if (ph_we_r) begin
      if (ph_addr_r[7:4] == `EPE_A_SEGW) begin
        segw_r[ph_addr_r[3:2]] <= I_HWDATA;
      end
      case (ph_addr_r)
        `EPE_A_CTRL: ctrl_r <= epe_ctrl_t'(I_HWDATA[7:0]);
        `EPE_A_THR: thr_r <= I_HWDATA[PW-1:0];
        `EPE_A_ROI: begin
          roi_lo_r <= (I_HWDATA[6:0] > `EPE_PCT_FULL) ? `EPE_PCT_FULL : I_HWDATA[6:0];
          roi_hi_r <= (I_HWDATA[`EPE_ROI_HI_LSB +: 7] > `EPE_PCT_FULL) ? `EPE_PCT_FULL
                    : I_HWDATA[`EPE_ROI_HI_LSB +: 7];
        end
        `EPE_A_RATE: begin
          if (I_HWDATA[31:0] < 32'(RMIN)) begin
            rate_r <= RMIN;
          end else if (I_HWDATA[31:0] > 32'(RMAX)) begin
            rate_r <= RMAX;
          end else begin
            rate_r <= I_HWDATA[12:0];
          end
        end
        `EPE_A_FHI: fhi_r <= I_HWDATA[15:0];
        `EPE_A_FLO: flo_r <= I_HWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Measurement rate by phase accumulation: exact 1 Hz steps, no divider
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      acc_r <= 28'h0;
      tick_r <= 1'b0;
    end else begin
      logic [12:0] reff;
      reff = (ctrl_r.stream && rate_r > RSTRM) ? RSTRM : rate_r;
      if (acc_r + 28'(reff) >= CLK_HZ) begin
        acc_r <= acc_r + 28'(reff) - CLK_HZ;
        tick_r <= 1'b1;
      end else begin
        acc_r <= acc_r + 28'(reff);
        tick_r <= 1'b0;
      end
    end
  end

  // Timestamp in microseconds; clear wins over the tick
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      us_r <= 8'h0;
      ts_r <= 32'h0;
    end else if (clr_ts) begin
      us_r <= 8'h0;
      ts_r <= 32'h0;
    end else if (us_r == 8'(TS_CYC - 1)) begin
      us_r <= 8'h0;
      ts_r <= ts_r + 32'h1;
    end else begin
      us_r <= us_r + 8'h1;
    end
  end

  // Measurement counter
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_r <= 32'h0;
    end else if (clr_cnt) begin
      cnt_r <= 32'h0;
    end else if (state_r == EPE_DONE) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Sequencer; a tick that finds a measurement running is dropped
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= EPE_IDLE;
    end else begin
      unique case (state_r)
        EPE_IDLE: if (tick_r) state_r <= EPE_ACQ;
        EPE_ACQ: if (I_PIX_VALID && idx_r == IW'(NPIX - 1) && fdn_r + 1'b1 == nfr_r) state_r <= EPE_WALK;
        EPE_WALK: if (wk_r == ecnt_r) state_r <= EPE_DONE;
        EPE_DONE: state_r <= EPE_IDLE;
      endcase
    end
  end

  // Line requests spaced by the least line period, frame count per mode
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_LINE_REQ <= 1'b0;
      O_EXPO_FIXED <= 1'b0;
      gap_r <= '0;
      frq_r <= '0;
      nfr_r <= '0;
      line_act_r <= 1'b0;
      lo_r <= '0;
      hi_r <= '0;
    end else begin
      O_LINE_REQ <= 1'b0;
      O_EXPO_FIXED <= ~ctrl_r.avg_en;
      if (gap_r != '0) gap_r <= gap_r - 1'b1;
      if (state_r == EPE_IDLE && tick_r) begin
        nfr_r <= ctrl_r.avg_en ? (FSH + 1)'(AVG_FRAMES) : (FSH + 1)'(1);
        frq_r <= '0;
        lo_r <= IW'((32'(roi_lo_r) * NPIX) / 100);
        hi_r <= IW'((32'(roi_hi_r) * NPIX) / 100);
      end else if (state_r == EPE_ACQ) begin
        if (!line_act_r && gap_r == '0 && frq_r != nfr_r) begin
          O_LINE_REQ <= 1'b1;
          gap_r <= GW'(LINE_GAP_CYC - 1);
          frq_r <= frq_r + 1'b1;
          line_act_r <= 1'b1;
        end else if (I_PIX_VALID && idx_r == IW'(NPIX - 1)) begin
          line_act_r <= 1'b0;
        end
      end
    end
  end

  // Pixel index and frame count within the measurement
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      idx_r <= '0;
      fdn_r <= '0;
    end else if (state_r != EPE_ACQ) begin
      idx_r <= '0;
      fdn_r <= '0;
    end else if (I_PIX_VALID) begin
      if (idx_r == IW'(NPIX - 1)) begin
        idx_r <= '0;
        fdn_r <= fdn_r + 1'b1;
      end else begin
        idx_r <= idx_r + 1'b1;
      end
    end
  end

  // Running per-pixel sum; the last frame is evaluated on the fly
  logic [SW-1:0] sum_in;
  logic [PW-1:0] avg_px;
  logic is_light, last_fr;
  always_comb begin
    sum_in = (fdn_r == '0) ? SW'(I_PIX_DATA) : sum_mem[idx_r[IW-2:0]] + SW'(I_PIX_DATA);
    avg_px = ctrl_r.avg_en ? PW'(sum_in >> FSH) : I_PIX_DATA;
    is_light = avg_px >= thr_r;
    last_fr = (fdn_r + 1'b1 == nfr_r);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (state_r == EPE_ACQ && I_PIX_VALID) begin
      sum_mem[idx_r[IW-2:0]] <= sum_in;
    end
  end

  // Edge capture inside the window, ascending pixel order, up to 16
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prev_light_r <= 1'b0;
      ecnt_r <= 5'h0;
      epol_r <= 16'h0;
      for (int i = 0; i < 16; i++) epos_r[i] <= '0;
    end else if (state_r == EPE_IDLE && tick_r) begin
      ecnt_r <= 5'h0;
    end else if (state_r == EPE_ACQ && I_PIX_VALID && last_fr) begin
      prev_light_r <= is_light;
      if (idx_r > lo_r && idx_r < hi_r && is_light != prev_light_r && ecnt_r != 5'h10) begin
        epos_r[ecnt_r[3:0]] <= idx_r;
        epol_r[ecnt_r[3:0]] <= is_light;
        ecnt_r <= ecnt_r + 5'h1;
      end
    end
  end

  // Walk the edges in search order, one per cycle, picking program results
  logic [3:0] wj;
  logic wpol;
  epe_res_t wres;
  always_comb begin
    wj = ctrl_r.search_rev ? 4'(ecnt_r - 5'h1 - wk_r) : wk_r[3:0];
    wpol = epol_r[wj] ^ ctrl_r.search_rev; // 1: dark to light along the scan
    wres.val = 1'b1;
    wres.pos = rel({epos_r[wj], 1'b0} - 1'b1);
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wk_r <= 5'h0;
      ra_r <= '0;
      rb_r <= '0;
      gap_open_r <= 1'b0;
      for (int i = 0; i < 16; i++) ord_r[i] <= '0;
    end else if (state_r == EPE_IDLE && tick_r) begin
      wk_r <= 5'h0;
      ra_r <= '0;
      rb_r <= '0;
      gap_open_r <= 1'b0;
      for (int i = 0; i < 16; i++) ord_r[i] <= '0;
    end else if (state_r == EPE_WALK && wk_r != ecnt_r) begin
      wk_r <= wk_r + 5'h1;
      ord_r[wk_r[3:0]] <= wres;
      case (ctrl_r.prog)
        EPE_RISE: if (!ra_r.val && wpol) ra_r <= wres;
        EPE_DIAM: begin
          if (!ra_r.val && !wpol) ra_r <= wres;
          if (wpol) rb_r <= wres;
        end
        EPE_GAP: begin
          if (!ra_r.val && wpol) begin
            ra_r <= wres;
            gap_open_r <= 1'b1;
          end else if (gap_open_r && !rb_r.val && !wpol) begin
            rb_r <= wres;
          end
        end
        EPE_SEG: begin
          if (!ra_r.val) ra_r <= wres;
          rb_r <= wres;
        end
        default: if (!ra_r.val && !wpol) ra_r <= wres;
      endcase
    end
  end

  // Segment results from edge pairs; 0-0 pairs stay undefined
  for (genvar g = 0; g < 8; g++) begin : g_seg
    wire [15:0] sdef = segw_r[g / 2][(g % 2) * 16 +: 16];
    wire [4:0] na = sdef[4:0];
    wire [4:0] nb = sdef[`EPE_SEG_B_LSB +: 5];
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        seg_r[g] <= '0;
      end else if (state_r == EPE_DONE) begin
        epe_res_t pa, pb;
        pa = pick(na);
        pb = pick(nb);
        seg_r[g].val <= pa.val & pb.val & ((na | nb) != 5'h00);
        seg_r[g].pos <= pb.pos - pa.pos;
      end
    end
  end

  // Overshoot filter on the primary value, then result outputs
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fact_r <= 1'b0;
      held_r <= 16'sh0;
      O_RESULT <= 16'h0;
      O_RESULT_VALID <= 1'b0;
      O_MEAS_DONE <= 1'b0;
      O_FILT_ACTIVE <= 1'b0;
    end else begin
      O_MEAS_DONE <= (state_r == EPE_DONE);
      O_FILT_ACTIVE <= fact_r;
      if (!ctrl_r.filt_en) fact_r <= 1'b0;
      if (state_r == EPE_DONE) begin
        O_RESULT_VALID <= ra_r.val;
        if (ra_r.val) begin
          if (ra_r.pos < fhi_r) held_r <= ra_r.pos;
          if (ctrl_r.filt_en && !fact_r && ra_r.pos > fhi_r) begin
            fact_r <= 1'b1;
            O_RESULT <= held_r;
          end else if (ctrl_r.filt_en && fact_r && ra_r.pos < flo_r) begin
            fact_r <= 1'b0;
            O_RESULT <= ra_r.pos;
          end else if (ctrl_r.filt_en && fact_r) begin
            O_RESULT <= held_r;
          end else begin
            O_RESULT <= ra_r.pos;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- epe_defs.svh ----
// Constants of the edge position evaluator: register offsets, fields,
// reset values and timing figures.
// Assumes inclusion by bare name from the design file.
`ifndef EPE_DEFS_SVH
`define EPE_DEFS_SVH
`define EPE_A_CTRL 8'h00
`define EPE_A_THR 8'h04
`define EPE_A_ROI 8'h08
`define EPE_A_RATE 8'h0c
`define EPE_A_FHI 8'h10
`define EPE_A_FLO 8'h14
`define EPE_A_CMD 8'h18
`define EPE_A_STAT 8'h1c
`define EPE_A_SEGW 4'h2
`define EPE_A_CNT 8'h30
`define EPE_A_TS 8'h34
`define EPE_A_RESA 8'h38
`define EPE_A_RESB 8'h3c
`define EPE_A_EDGE 2'b01
`define EPE_A_SEG 3'b100
`define EPE_ROI_HI_LSB 8
`define EPE_SEG_B_LSB 8
`define EPE_CMD_CLR_CNT 0
`define EPE_CMD_CLR_TS 1
`define EPE_NOPEAK 32'h8000_0000
`define EPE_CTRL_RST 8'h20
`define EPE_THR_RST 12'h800
`define EPE_ROI_LO_RST 7'h00
`define EPE_ROI_HI_RST 7'h64
`define EPE_PCT_FULL 7'h64
`define EPE_RATE_RST 13'h03e8
`define EPE_SEGW0_RST 32'h0302_0201
`define EPE_SEGW1_RST 32'h0000_0403
`define EPE_CLK_HZ 200000000
`define EPE_CLK_NS 5
`define EPE_RATE_MIN_HZ 100
`define EPE_RATE_MAX_HZ 5000
`define EPE_STREAM_HZ 100
`define EPE_LINE_MAX_HZ 15000
`define EPE_TS_UNIT_NS 1000
`endif

// ---- epe_pkg.sv ----
// Types shared by the edge position evaluator.
// Assumes nothing beyond a SystemVerilog compiler.
package epe_pkg;
  typedef enum logic [2:0] {
    EPE_FALL = 3'b000, EPE_RISE = 3'b001, EPE_DIAM = 3'b010,
    EPE_GAP = 3'b011, EPE_SEG = 3'b100
  } epe_prog_t;
  typedef enum logic [1:0] {
    EPE_IDLE = 2'b00, EPE_ACQ = 2'b01, EPE_WALK = 2'b10, EPE_DONE = 2'b11
  } epe_state_t;
  typedef struct packed {
    logic stream;
    logic filt_en;
    logic avg_en;
    logic meas_inv;
    logic search_rev;
    epe_prog_t prog;
  } epe_ctrl_t;
  typedef struct packed {
    logic val;
    logic signed [15:0] pos;
  } epe_res_t;
endpackage

// ---- epe_top_assertions.sv ----
// Port-level checker for the edge position evaluator.
// Assumes one clock domain and binding onto every epe_top instance.
`timescale 1ns/1ps
`default_nettype none
module epe_top_assertions #(
  parameter int NPIX = 1024,
  parameter int LINE_GAP_CYC = 20
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic I_PIX_VALID,
  input wire logic O_LINE_REQ,
  input wire logic O_MEAS_DONE,
  input wire logic [15:0] O_RESULT,
  input wire logic O_RESULT_VALID
);
  logic [15:0] gap_r, pix_r, age_r;
  logic rd_addr;
  assign rd_addr = I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HREADY;
  // Line spacing, pixels per line and age of the last pixel; spacing and age counters saturate
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gap_r <= 16'hffff;
      pix_r <= 16'(NPIX);
      age_r <= 16'hffff;
    end else begin
      gap_r <= O_LINE_REQ ? 16'h0001 : gap_r + {15'h0000, gap_r != 16'hffff};
      pix_r <= O_LINE_REQ ? 16'h0000 : pix_r + {15'h0000, I_PIX_VALID};
      age_r <= I_PIX_VALID ? 16'h0000 : age_r + {15'h0000, age_r != 16'hffff};
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_req_pulse;
    O_LINE_REQ ##1 !O_LINE_REQ;
  endsequence
  sequence s_done_pulse;
    O_MEAS_DONE ##1 !O_MEAS_DONE;
  endsequence
  chk_ready_high: assert property (O_HREADYOUT) else $error("hreadyout dropped");
  chk_resp_okay: assert property (!O_HRESP) else $error("hresp not okay");
  chk_req_pulse: assert property (O_LINE_REQ |-> s_req_pulse) else $error("line request too long");
  chk_req_gap: assert property (O_LINE_REQ |-> gap_r >= LINE_GAP_CYC)
    else $error("line requests too close");
  chk_line_whole: assert property (O_LINE_REQ |-> pix_r >= NPIX)
    else $error("line request before line complete");
  chk_done_pulse: assert property (O_MEAS_DONE |-> s_done_pulse) else $error("done too long");
  chk_done_lag: assert property (O_MEAS_DONE |-> age_r inside {[1:40]})
    else $error("done not after last pixel");
  chk_result_done: assert property ($changed({O_RESULT_VALID, O_RESULT}) |-> O_MEAS_DONE)
    else $error("result moved without done");
  chk_rdata_hold: assert property (!$past(rd_addr) |-> $stable(O_HRDATA))
    else $error("read data moved outside a read");
endmodule
bind epe_top epe_top_assertions #(.NPIX(NPIX), .LINE_GAP_CYC(LINE_GAP_CYC)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
  .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP), .I_PIX_VALID(I_PIX_VALID), .O_LINE_REQ(O_LINE_REQ),
  .O_MEAS_DONE(O_MEAS_DONE), .O_RESULT(O_RESULT), .O_RESULT_VALID(O_RESULT_VALID)
);
`default_nettype wire

// ---- epe_line_cam.sv ----
// Line camera front end model: one line of NPIX pixels per request.
// Assumes the evaluator's clock; light spans 0..3 and 10.., dark between.
`timescale 1ns/1ps
`default_nettype none
module epe_line_cam #(
  parameter int NPIX = 16,
  parameter int PW = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_line_req,
  input wire logic i_slow,
  input wire logic [PW-1:0] i_light,
  input wire logic [PW-1:0] i_dark,
  output logic o_pix_valid,
  output logic [PW-1:0] o_pix_data
);
  int cnt;
  logic act, ph;
  // Slow mode stalls every other cycle; idle data toggles so stale values never match
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act <= 1'b0;
      cnt <= 0;
      ph <= 1'b0;
      o_pix_valid <= 1'b0;
      o_pix_data <= '0;
    end else begin
      ph <= ~ph;
      if (i_line_req) begin
        act <= 1'b1;
        cnt <= 0;
      end
      if (act && !(i_slow && ph)) begin
        o_pix_valid <= 1'b1;
        o_pix_data <= (cnt < 4 || cnt >= 10) ? i_light : i_dark;
        cnt <= cnt + 1;
        if (cnt == NPIX - 1) act <= 1'b0;
      end else begin
        o_pix_valid <= 1'b0;
        o_pix_data <= ~o_pix_data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- epe_top_test.sv ----
// Self-checking bench for the edge position evaluator.
// Assumes the camera model and the bound checker; NPIX 16, short line gap.
`timescale 1ns/1ps
`default_nettype none
module epe_top_test;
  import epe_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic slow = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val;
  logic hreadyout, hresp, pix_valid, line_req, expo_fixed, meas_done, res_valid, filt_active;
  logic [11:0] pix_data, light_lvl = 12'hfff, dark_lvl = 12'h000;
  logic [15:0] result;
  logic [31:0] rd_q[$], res_q[$];
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'hf0};
  logic [31:0] rv [10] = '{32'h20, 32'h800, 32'h6400, 32'h3e8, 32'h7fff, 32'h0, 32'h0,
    32'h3020201, 32'h403, 32'h0};
  event rd_ev;
  int error_cnt = 0, cmp_count = 0, done_n = 0;
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  epe_top #(.NPIX(16), .LINE_GAP_CYC(20)) dut (
    .I_REF_CLK(ref_clk), .I_RESETN(resetn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata),
    .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_PIX_VALID(pix_valid), .I_PIX_DATA(pix_data),
    .O_LINE_REQ(line_req), .O_EXPO_FIXED(expo_fixed), .O_MEAS_DONE(meas_done), .O_RESULT(result),
    .O_RESULT_VALID(res_valid), .O_FILT_ACTIVE(filt_active));
  epe_line_cam cam (
    .i_clk(ref_clk), .i_rst_n(resetn), .i_line_req(line_req), .i_slow(slow), .i_light(light_lvl),
    .i_dark(dark_lvl), .o_pix_valid(pix_valid), .o_pix_data(pix_data));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One single AHB-Lite transfer; hready is polled, never assumed
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hsize <= 3'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
    ->rd_ev;
  endtask
  task wait_done(input int n);
    for (int k = 0; k < 60000 && done_n < n; k++) @(posedge ref_clk);
    if (done_n < n) error_cnt++;
  endtask
  // Result monitors take the oldest expectation; outputs sampled mid-cycle where settled
  always @(rd_ev) chk(rd_val, rd_q.pop_front());
  always @(negedge ref_clk) begin
    if (meas_done === 1'b1) begin
      done_n++;
      chk({15'h0, res_valid, result}, res_q.pop_front());
    end
  end
  // Each measurement at 5 kHz costs 40000 cycles, so the limit covers two
  initial begin
    repeat (95000) @(posedge ref_clk);
    error_cnt++;
    test_done;
  end
  initial begin
    void'($urandom(32'h0331));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    light_lvl <= 12'h800 + 12'($urandom_range(2047));
    dark_lvl <= 12'($urandom_range(2047));
    foreach (ra[i]) rd(ra[i], rv[i]);
    bus(1'b1, 8'h0c, 32'h1fff);
    rd(8'h0c, 32'h1388);
    bus(1'b1, 8'h08, 32'h6400);
    // Segment program, standard search, averaging off, filter enabled
    bus(1'b1, 8'h00, 32'h44);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, expo_fixed}, 32'h1);
    res_q.push_back(32'h1fff7);
    wait_done(1);
    rd(8'h38, 32'hfffffff7);
    rd(8'h3c, 32'h3);
    rd(8'h40, 32'hfffffff7);
    rd(8'h44, 32'h3);
    rd(8'h48, 32'h80000000);
    rd(8'h80, 32'hc);
    rd(8'h1c, 32'h2);
    rd(8'h30, 32'h1);
    bus(1'b1, 8'h18, 32'h1);
    rd(8'h30, 32'h0);
    bus(1'b0, 8'h34, 32'h0);
    chk({31'h0, rd_val != 32'h0}, 32'h1);
    // Reverse falling search, inverse, averaged, slow camera; value exceeds upper bound
    bus(1'b1, 8'h10, 32'hfffb);
    bus(1'b1, 8'h14, 32'hffec);
    slow <= 1'b1;
    bus(1'b1, 8'h00, 32'h78);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, expo_fixed}, 32'h0);
    res_q.push_back(32'h1fff7);
    wait_done(2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, filt_active}, 32'h1);
    rd(8'h40, 32'hfffffffd);
    rd(8'h44, 32'h9);
    test_done;
  end
endmodule
`default_nettype wire
